/* File: design/hidd_decoder.sv */
// Decided for this implementation: the placing of the registers and register access over AHB-Lite.
`include "hidd_consts.svh"
`default_nettype none
module hidd_decoder import hidd_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic sof_pulse,
  input wire logic [4:0] bus_frame,
  input wire logic [2:0] bus_uframe,
  output logic xfer_valid,
  input wire logic xfer_ready,
  output hidd_xfer_s xfer_out,
  input wire logic xfer_done,
  input wire hidd_result_s xfer_result,
  output logic busy
);

  //////////////////////////////////////////////////////////////////////////
  // Bus slave state.

  logic wr_pend_reg, wr_pend_next;
  logic [7:0] wr_addr_reg, wr_addr_next;
  logic [31:0] rdata_reg, rdata_next;

  // Descriptor fields.
  logic valid_reg, valid_next;
  logic halt_reg, halt_next;
  logic babble_reg, babble_next;
  logic [14:0] done_reg, done_next;
  logic [14:0] toxfer_reg, toxfer_next;
  logic [10:0] maxpkt_reg, maxpkt_next;
  logic [1:0] mult_reg, mult_next;
  logic [3:0] ep_reg, ep_next;
  logic [6:0] devaddr_reg, devaddr_next;
  logic [1:0] token_reg, token_next;
  logic [1:0] kind_reg, kind_next;
  logic split_reg, split_next;
  logic [15:0] ptr_reg, ptr_next;
  logic [7:0] frame_reg, frame_next;
  logic [7:0] mask_reg, mask_next;

  // Engine state.
  hidd_state_e state_reg, state_next;
  logic [1:0] left_reg, left_next;
  logic [2:0] uf_reg, uf_next;
  hidd_xfer_s xfer_reg, xfer_next;

  logic go;
  logic addr_phase;
  logic wr_en;
  logic [15:0] sum;
  logic [14:0] sum_cap;
  logic [7:0] mask_left;
  logic last_pkt;
  logic reached;
  logic [31:0] word0, word1, word2, word3, word4;

  //////////////////////////////////////////////////////////////////////////
  // Readback views; reserved bits read as zero.

  assign word0 = {ep_reg[0], mult_reg, maxpkt_reg, toxfer_reg, 2'h0,
                  valid_reg};
  assign word1 = {17'h0, split_reg, kind_reg, token_reg, devaddr_reg,
                  ep_reg[3:1]};
  assign word2 = {8'h0, ptr_reg, frame_reg};
  // The active bit mirrors valid.
  assign word3 = {valid_reg, halt_reg, babble_reg, 14'h0, done_reg};
  assign word4 = {24'h0, mask_reg};

  // Zero wait states and only OKAY answers; read data leaves a flip-flop.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_reg;
  assign addr_phase = hsel && hready && (htrans == `HIDD_HTRANS_NONSEQ);
  assign wr_en = wr_pend_reg;

  //////////////////////////////////////////////////////////////////////////
  // Address phase capture; read data is sampled from the current words.

  always_comb begin
    wr_pend_next = addr_phase && hwrite;
    wr_addr_next = wr_addr_reg;
    rdata_next = rdata_reg;
    if (addr_phase) begin
      wr_addr_next = haddr[7:0];
    end
    if (addr_phase && !hwrite) begin
      unique case (haddr[7:0])
        `HIDD_OFS_WORD0: rdata_next = word0;
        `HIDD_OFS_WORD1: rdata_next = word1;
        `HIDD_OFS_WORD2: rdata_next = word2;
        `HIDD_OFS_WORD3: rdata_next = word3;
        `HIDD_OFS_WORD4: rdata_next = word4;
        default: rdata_next = `HIDD_RST_WORD;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      rdata_reg <= `HIDD_RST_WORD;
    end else begin
      wr_pend_reg <= wr_pend_next;
      wr_addr_reg <= wr_addr_next;
      rdata_reg <= rdata_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Slot eligibility for the current microframe.

  hidd_slot_match u_slot (
    .sof_pulse(sof_pulse),
    .valid(valid_reg),
    .halt(halt_reg),
    .kind(kind_reg),
    .token(token_reg),
    .mult(mult_reg),
    .frame_sel(frame_reg),
    .bus_frame(bus_frame),
    .bus_uframe(bus_uframe),
    .mask(mask_reg),
    .go(go)
  );

  // Running total, saturated below 32 kB.
  assign sum = {1'b0, done_reg} + {5'h00, xfer_result.bytes};
  assign sum_cap = sum[15] ? `HIDD_BYTES_MAX : sum[14:0];
  assign reached = (sum_cap >= toxfer_reg);
  assign last_pkt = (left_reg == 2'h1) ||
                    (xfer_result.bytes < xfer_reg.max_packet_bytes);
  assign mask_left = mask_reg & ~(8'h01 << uf_reg);

  //////////////////////////////////////////////////////////////////////////
  // Engine and descriptor update. Hardware effects are applied first and
  // software writes are overlaid, so a set never loses to a clear.

  always_comb begin
    state_next = state_reg;
    left_next = left_reg;
    uf_next = uf_reg;
    xfer_next = xfer_reg;
    valid_next = valid_reg;
    halt_next = halt_reg;
    babble_next = babble_reg;
    done_next = done_reg;
    toxfer_next = toxfer_reg;
    maxpkt_next = maxpkt_reg;
    mult_next = mult_reg;
    ep_next = ep_reg;
    devaddr_next = devaddr_reg;
    token_next = token_reg;
    kind_next = kind_reg;
    split_next = split_reg;
    ptr_next = ptr_reg;
    frame_next = frame_reg;
    mask_next = mask_reg;
    unique case (state_reg)
      HIDD_ST_IDLE: begin
        if (go) begin
          state_next = HIDD_ST_ISSUE;
          left_next = mult_reg;
          uf_next = bus_uframe;
          xfer_next.is_in = (token_reg == `HIDD_TOKEN_IN);
          xfer_next.split = split_reg;
          xfer_next.dev_addr = devaddr_reg;
          xfer_next.endpoint_number = ep_reg;
          xfer_next.payload_ram_pointer = ptr_reg;
          // Any size up to the limit passes; larger is clipped.
          xfer_next.max_packet_bytes =
            (maxpkt_reg > `HIDD_ISO_MAX_PKT) ? `HIDD_ISO_MAX_PKT
                                             : maxpkt_reg;
        end
      end
      HIDD_ST_ISSUE: begin
        if (xfer_ready) begin
          state_next = HIDD_ST_WAIT;
        end
      end
      HIDD_ST_WAIT: begin
        if (xfer_done) begin
          // Each packet adds to the field, so totals show early.
          done_next = sum_cap;
          left_next = left_reg - 2'h1;
          if (xfer_result.stall) begin
            halt_next = 1'b1;
            valid_next = 1'b0;
            state_next = HIDD_ST_IDLE;
          end else if (xfer_result.fatal) begin
            valid_next = 1'b0;
            state_next = HIDD_ST_IDLE;
          end else if (last_pkt || reached) begin
            mask_next = mask_left;
            if (mask_left == 8'h00 || reached) begin
              valid_next = 1'b0;
            end
            state_next = HIDD_ST_IDLE;
          end else begin
            state_next = HIDD_ST_ISSUE;
          end
        end
      end
    endcase
    if (wr_en) begin
      unique case (wr_addr_reg)
        `HIDD_OFS_WORD0: begin
          ep_next[0] = hwdata[`HIDD_W0_EP0];
          mult_next = hwdata[`HIDD_W0_MULT_LSB +: 2];
          maxpkt_next = hwdata[`HIDD_W0_MAXPKT_LSB +: 11];
          toxfer_next = hwdata[`HIDD_W0_TOXFER_LSB +: 15];
          valid_next = valid_next | hwdata[`HIDD_W0_VALID];
        end
        `HIDD_OFS_WORD1: begin
          // Reserved bits are expected zero and are not stored.
          split_next = hwdata[`HIDD_W1_SPLIT];
          kind_next = hwdata[`HIDD_W1_KIND_LSB +: 2];
          token_next = hwdata[`HIDD_W1_TOKEN_LSB +: 2];
          devaddr_next = hwdata[`HIDD_W1_DEVADDR_LSB +: 7];
          ep_next[3:1] = hwdata[`HIDD_W1_EPHI_LSB +: 3];
        end
        `HIDD_OFS_WORD2: begin
          // Software already scaled the pointer to memory words.
          ptr_next = hwdata[`HIDD_W2_PTR_LSB +: 16];
          frame_next = hwdata[`HIDD_W2_FRAME_LSB - 3 +: 8];
        end
        `HIDD_OFS_WORD3: begin
          valid_next = valid_next | hwdata[`HIDD_W3_ACTIVE];
          halt_next = halt_next | hwdata[`HIDD_W3_HALT];
          if (!(state_reg == HIDD_ST_WAIT && xfer_done)) begin
            halt_next = hwdata[`HIDD_W3_HALT];
            done_next = hwdata[`HIDD_W3_DONE_LSB +: 15];
          end
          // Stored for readback only; never steers the engine.
          babble_next = hwdata[`HIDD_W3_BABBLE];
        end
        `HIDD_OFS_WORD4: begin
          mask_next = mask_next | hwdata[`HIDD_W4_MASK_LSB +: 8];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= HIDD_ST_IDLE;
      left_reg <= 2'h0;
      uf_reg <= 3'h0;
      xfer_reg <= '0;
      valid_reg <= 1'b0;
      halt_reg <= 1'b0;
      babble_reg <= 1'b0;
      done_reg <= 15'h0000;
      toxfer_reg <= 15'h0000;
      maxpkt_reg <= 11'h000;
      mult_reg <= 2'h0;
      ep_reg <= 4'h0;
      devaddr_reg <= 7'h00;
      token_reg <= 2'h0;
      kind_reg <= 2'h0;
      split_reg <= 1'b0;
      ptr_reg <= 16'h0000;
      frame_reg <= 8'h00;
      mask_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      left_reg <= left_next;
      uf_reg <= uf_next;
      xfer_reg <= xfer_next;
      valid_reg <= valid_next;
      halt_reg <= halt_next;
      babble_reg <= babble_next;
      done_reg <= done_next;
      toxfer_reg <= toxfer_next;
      maxpkt_reg <= maxpkt_next;
      mult_reg <= mult_next;
      ep_reg <= ep_next;
      devaddr_reg <= devaddr_next;
      token_reg <= token_next;
      kind_reg <= kind_next;
      split_reg <= split_next;
      ptr_reg <= ptr_next;
      frame_reg <= frame_next;
      mask_reg <= mask_next;
    end
  end

  // The request handshake is combinational; its payload is registered.
  assign xfer_valid = (state_reg == HIDD_ST_ISSUE);
  assign xfer_out = xfer_reg;
  assign busy = (state_reg != HIDD_ST_IDLE);

  //////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic [14:0] sum_seen_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sum_seen_reg <= 15'h0000;
    end else begin
      sum_seen_reg <= sum_cap;
    end
  end

  sequence s_pkt_done;
    state_reg == HIDD_ST_WAIT && xfer_done && !xfer_result.stall &&
    !xfer_result.fatal && !wr_en;
  endsequence

  sequence s_start;
    state_reg == HIDD_ST_IDLE && go ##1 state_reg == HIDD_ST_ISSUE;
  endsequence

  a_stall_halts: assert property (
    state_reg == HIDD_ST_WAIT && xfer_done && xfer_result.stall
    |=> halt_reg && !valid_reg && state_reg == HIDD_ST_IDLE)
    else $error("stall did not set halt and clear valid");

  a_count_update: assert property (
    s_pkt_done |=> done_reg == sum_seen_reg && done_reg <= `HIDD_BYTES_MAX)
    else $error("moved-byte count not updated from packet result");

  a_pkt_limit: assert property (
    xfer_valid |-> xfer_out.max_packet_bytes <= `HIDD_ISO_MAX_PKT)
    else $error("packet size above the iso limit");

  a_start_fields: assert property (
    s_start |-> $past(bus_frame) == $past(frame_reg[7:3]) &&
    xfer_out.payload_ram_pointer == $past(ptr_reg) &&
    xfer_out.dev_addr == $past(devaddr_reg))
    else $error("request fields differ from descriptor at start");

  a_start_codes: assert property (
    s_start |-> xfer_out.split == $past(split_reg) &&
    xfer_out.is_in == $past(token_reg[0]) &&
    xfer_out.endpoint_number == $past(ep_reg))
    else $error("token, split or endpoint wrongly decoded");

  a_mask_gate: assert property (
    s_start |-> $past(mask_reg[bus_uframe]) && left_reg == $past(mult_reg))
    else $error("started in an inactive microframe");

  a_skip_invalid: assert property (
    state_reg == HIDD_ST_IDLE && !valid_reg && !wr_en
    |=> state_reg == HIDD_ST_IDLE && $stable(done_reg) &&
    $stable(mask_reg))
    else $error("invalid descriptor was touched");

  a_exec_end: assert property (
    s_pkt_done ##0 (last_pkt && mask_left == 8'h00)
    |=> !valid_reg ##1 state_reg == HIDD_ST_IDLE)
    else $error("valid not cleared after full execution");

  a_req_hold: assert property (
    xfer_valid && !xfer_ready |=> xfer_valid && $stable(xfer_out))
    else $error("request dropped or changed before acceptance");

endmodule // hidd_decoder
`default_nettype wire

/* File: design/hidd_consts.svh */
`ifndef HIDD_CONSTS_SVH
`define HIDD_CONSTS_SVH

// Byte offsets of the descriptor words on the register bus.
`define HIDD_OFS_WORD0 8'h00
`define HIDD_OFS_WORD1 8'h04
`define HIDD_OFS_WORD2 8'h08
`define HIDD_OFS_WORD3 8'h0C
`define HIDD_OFS_WORD4 8'h10

// Field positions within word 0.
`define HIDD_W0_EP0 31
`define HIDD_W0_MULT_LSB 29
`define HIDD_W0_MAXPKT_LSB 18
`define HIDD_W0_TOXFER_LSB 3
`define HIDD_W0_VALID 0

// Field positions within word 1.
`define HIDD_W1_SPLIT 14
`define HIDD_W1_KIND_LSB 12
`define HIDD_W1_TOKEN_LSB 10
`define HIDD_W1_DEVADDR_LSB 3
`define HIDD_W1_EPHI_LSB 0

// Field positions within words 2, 3 and 4.
`define HIDD_W2_PTR_LSB 8
`define HIDD_W2_FRAME_LSB 3
`define HIDD_W3_ACTIVE 31
`define HIDD_W3_HALT 30
`define HIDD_W3_BABBLE 29
`define HIDD_W3_DONE_LSB 0
`define HIDD_W4_MASK_LSB 0

// Codes, limits and reset values.
`define HIDD_KIND_ISO 2'h1
`define HIDD_TOKEN_OUT 2'h0
`define HIDD_TOKEN_IN 2'h1
`define HIDD_ISO_MAX_PKT 11'h400
`define HIDD_BYTES_MAX 15'h7FFF
`define HIDD_RST_WORD 32'h0000_0000
`define HIDD_HTRANS_NONSEQ 2'h2

`endif

/* File: design/hidd_pkg.sv */
`default_nettype none
package hidd_pkg;

  // Engine states, one-hot.
  typedef enum logic [2:0] {
    HIDD_ST_IDLE = 3'b001,
    HIDD_ST_ISSUE = 3'b010,
    HIDD_ST_WAIT = 3'b100
  } hidd_state_e;

  // One packet request toward the link side.
  typedef struct packed {
    logic is_in;
    logic split;
    logic [6:0] dev_addr;
    logic [3:0] endpoint_number;
    logic [10:0] max_packet_bytes;
    logic [15:0] payload_ram_pointer;
  } hidd_xfer_s;

  // Result of one packet from the link side.
  typedef struct packed {
    logic [10:0] bytes;
    logic stall;
    logic fatal;
  } hidd_result_s;

endpackage
`default_nettype wire

/* File: design/hidd_slot_match.sv */
`include "hidd_consts.svh"
`default_nettype none
module hidd_slot_match import hidd_pkg::*; (
  input wire logic sof_pulse,
  input wire logic valid,
  input wire logic halt,
  input wire logic [1:0] kind,
  input wire logic [1:0] token,
  input wire logic [1:0] mult,
  input wire logic [7:0] frame_sel,
  input wire logic [4:0] bus_frame,
  input wire logic [2:0] bus_uframe,
  input wire logic [7:0] mask,
  output logic go
);

  logic frame_hit;
  logic kind_ok;

  // Only bits 7..3 of the frame byte take part in the match.
  assign frame_hit = (frame_sel[7:3] == bus_frame);
  // Tokens other than OUT or IN and non-iso kinds are never run.
  assign kind_ok = (kind == `HIDD_KIND_ISO) && !token[1];

  // A cleared valid or a set halt skips the slot outright.
  always_comb begin
    go = sof_pulse && valid && !halt && kind_ok && frame_hit &&
         mask[bus_uframe] && (mult != 2'h0);
  end

endmodule // hidd_slot_match
`default_nettype wire

/* File: verification/hidd_endpoint_model.sv */
`default_nettype none
module hidd_endpoint_model import hidd_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic xfer_valid,
  input wire hidd_xfer_s xfer_out,
  output logic xfer_ready,
  output logic xfer_done,
  output hidd_result_s xfer_result,
  input wire logic [3:0] rdy_dly,
  input wire logic [3:0] done_dly,
  input wire logic stall_cmd,
  input wire logic fatal_cmd,
  input wire logic short_cmd,
  output hidd_xfer_s last_req,
  output logic [7:0] n_req
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt;
  logic pending;
  hidd_result_s held;

  ////////////////////////////////////////////////////////////////////////////
  // Accept after rdy_dly cycles, then finish after done_dly more cycles.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      xfer_ready <= 1'b0;
      xfer_done <= 1'b0;
      pending <= 1'b0;
      cnt <= 4'h0;
      n_req <= 8'h00;
      last_req <= '0;
      held <= '0;
    end else begin
      xfer_done <= 1'b0;
      if (xfer_valid && xfer_ready) begin
        xfer_ready <= 1'b0;
        pending <= 1'b1;
        cnt <= 4'h0;
        last_req <= xfer_out;
        n_req <= n_req + 8'h01;
      end else if (xfer_valid && !pending) begin
        if (cnt >= rdy_dly) begin
          xfer_ready <= 1'b1;
        end else begin
          cnt <= cnt + 4'h1;
        end
      end else if (pending) begin
        if (cnt >= done_dly) begin
          pending <= 1'b0;
          cnt <= 4'h0;
          xfer_done <= 1'b1;
          held.stall <= stall_cmd;
          held.fatal <= fatal_cmd;
          // A packet never carries more than the requested size.
          held.bytes <= (stall_cmd || fatal_cmd) ? 11'h000 :
            short_cmd ? last_req.max_packet_bytes - 11'h001 :
            last_req.max_packet_bytes;
        end else begin
          cnt <= cnt + 4'h1;
        end
      end
    end
  end

  // Outside the done pulse the lines show garbage, so no stale result helps.
  assign xfer_result = xfer_done ? held : ~held;
endmodule // hidd_endpoint_model
`default_nettype wire

/* File: verification/hs_iso_descriptor_decoder_tb_top.sv */
`include "hidd_consts.svh"
`default_nettype none
module hs_iso_descriptor_decoder_tb_top import hidd_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] DEV = 7'h5A;
  localparam logic [4:0] FRM = 5'h13;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize, bus_uframe;
  logic sof_pulse, xfer_valid, xfer_ready, xfer_done, busy;
  logic [4:0] bus_frame;
  hidd_xfer_s xfer_out, last_req, exp_req;
  hidd_result_s xfer_result;
  logic [3:0] rdy_dly, done_dly;
  logic stall_cmd, fatal_cmd, short_cmd;
  logic [7:0] n_req;
  int n_fail = 0;
  int compares = 0;

  assign hready = hreadyout;
  hidd_decoder u_hidd_decoder (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .sof_pulse(sof_pulse), .bus_frame(bus_frame),
    .bus_uframe(bus_uframe), .xfer_valid(xfer_valid),
    .xfer_ready(xfer_ready), .xfer_out(xfer_out), .xfer_done(xfer_done),
    .xfer_result(xfer_result), .busy(busy));
  hidd_endpoint_model u_hidd_endpoint_model (.hclk(hclk), .hresetn(hresetn),
    .xfer_valid(xfer_valid), .xfer_out(xfer_out), .xfer_ready(xfer_ready),
    .xfer_done(xfer_done), .xfer_result(xfer_result), .rdy_dly(rdy_dly),
    .done_dly(done_dly), .stall_cmd(stall_cmd), .fatal_cmd(fatal_cmd),
    .short_cmd(short_cmd), .last_req(last_req), .n_req(n_req));

  // The clock runs at 125 MHz.
  initial hclk = 1'b0;
  always #4 hclk = ~hclk;

  ////////////////////////////////////////////////////////////////////////////
  // One single AHB transfer; the wait loops never assume a latency.
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= `HIDD_HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_req(input hidd_xfer_s got, input hidd_xfer_s exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Reads a word and compares only the bits under the mask.
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk32(x & m, exp);
  endtask

  task automatic rst();
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
  endtask

  // Pulses a microframe start and waits, bounded, for the engine to settle.
  task automatic sof(input logic [4:0] f, input logic [2:0] u);
    int i;
    @(posedge hclk);
    sof_pulse <= 1'b1;
    bus_frame <= f;
    bus_uframe <= u;
    @(posedge hclk);
    sof_pulse <= 1'b0;
    i = 0;
    do begin
      @(posedge hclk);
      i++;
    end while (busy !== 1'b0 && i < 200);
  endtask

  // Builds a descriptor; the valid word goes last so nothing runs half-made.
  task automatic load(input logic [3:0] ep, input logic [1:0] mult,
    input logic [10:0] mp, input logic [14:0] btt, input logic sp,
    input logic [1:0] tok, input logic [31:0] cpu, input logic [7:0] mask,
    input logic [31:0] w3);
    logic [15:0] ptr;
    ptr = 16'((cpu - 32'h400) >> 3);
    wr(`HIDD_OFS_WORD1,
       {17'h0, sp, `HIDD_KIND_ISO, tok, DEV, ep[3:1]});
    wr(`HIDD_OFS_WORD2, {8'h00, ptr, FRM, 3'h5});
    wr(`HIDD_OFS_WORD3, w3);
    wr(`HIDD_OFS_WORD4, {24'h0, mask});
    wr(`HIDD_OFS_WORD0, {ep[0], mult, mp, btt, 3'h1});
    exp_req = '{tok == 2'h1, sp, DEV, ep, (mp > 11'h400) ? 11'h400 : mp, ptr};
  endtask

  task automatic close_out();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // A hang is cut short well beyond the few hundred cycles the tests need.
  initial begin
    repeat (20000) @(posedge hclk);
    n_fail++;
    close_out();
  end

  // Main sequence of scenarios.
  initial begin
    {hresetn, hsel, hwrite, sof_pulse, stall_cmd, fatal_cmd, short_cmd} = '0;
    {haddr, hwdata, htrans, bus_frame, bus_uframe} = '0;
    hsize = 3'h2;
    rdy_dly = 4'h3;
    done_dly = 4'h5;
    rst();
    for (int i = 0; i < 6; i++) rdchk(8'(i * 4), 32'hFFFF_FFFF, 32'h0);
    wr(8'h14, 32'hFFFF_FFFF);
    rdchk(8'h14, 32'hFFFF_FFFF, 32'h0);
    // The slave never answers with an error response.
    chk32({31'h0, hresp}, 32'h0);
    // Slow endpoint, OUT, frame and microframe filtering.
    load(4'hB, 2'h1, 11'h200, 15'h200, 1'b0, `HIDD_TOKEN_OUT, 32'h1400,
         8'h04, 32'h0);
    sof(FRM ^ 5'h01, 3'h2);
    sof(FRM, 3'h1);
    chk32(32'(n_req), 32'h0);
    sof(FRM, 3'h2);
    chk32(32'(n_req), 32'h1);
    chk_req(last_req, exp_req);
    rdchk(`HIDD_OFS_WORD3, 32'h7FFF, 32'h200);
    rdchk(`HIDD_OFS_WORD0, 32'h1, 32'h0);
    rdchk(`HIDD_OFS_WORD4, 32'hFF, 32'h0);
    // Prompt endpoint, IN split, three full packets of a clipped size.
    rst();
    rdy_dly <= 4'h0;
    done_dly <= 4'h0;
    load(4'h6, 2'h3, 11'h7FF, 15'h7FFF, 1'b1, `HIDD_TOKEN_IN, 32'h2000,
         8'h80, 32'h0);
    sof(FRM, 3'h7);
    chk32(32'(n_req), 32'h3);
    chk_req(last_req, exp_req);
    rdchk(`HIDD_OFS_WORD3, 32'h7FFF, 32'hC00);
    // A short packet ends the microframe, then a stall halts the descriptor.
    rst();
    short_cmd <= 1'b1;
    load(4'h1, 2'h2, 11'h100, 15'h7FFF, 1'b0, `HIDD_TOKEN_OUT, 32'h0400,
         8'h03, 32'h0);
    sof(FRM, 3'h0);
    chk32(32'(n_req), 32'h1);
    rdchk(`HIDD_OFS_WORD3, 32'h7FFF, 32'hFF);
    rdchk(`HIDD_OFS_WORD4, 32'hFF, 32'h02);
    rdchk(`HIDD_OFS_WORD0, 32'h1, 32'h1);
    short_cmd <= 1'b0;
    stall_cmd <= 1'b1;
    sof(FRM, 3'h1);
    stall_cmd <= 1'b0;
    rdchk(`HIDD_OFS_WORD3, 32'hC000_7FFF, 32'h4000_00FF);
    rdchk(`HIDD_OFS_WORD0, 32'h1, 32'h0);
    rdchk(`HIDD_OFS_WORD4, 32'hFF, 32'h02);
    sof(FRM, 3'h1);
    chk32(32'(n_req), 32'h2);
    rdchk(`HIDD_OFS_WORD3, 32'hC000_7FFF, 32'h4000_00FF);
    // A fatal result drops valid without halting.
    rst();
    fatal_cmd <= 1'b1;
    load(4'h3, 2'h1, 11'h040, 15'h7FFF, 1'b0, `HIDD_TOKEN_IN, 32'h0600,
         8'h01, 32'h0);
    sof(FRM, 3'h0);
    fatal_cmd <= 1'b0;
    rdchk(`HIDD_OFS_WORD3, 32'hC000_0000, 32'h0);
    rdchk(`HIDD_OFS_WORD0, 32'h1, 32'h0);
    // Count saturates; a preset babble bit does not stop the run.
    rst();
    rdy_dly <= 4'h2;
    done_dly <= 4'h1;
    load(4'h2, 2'h1, 11'h100, 15'h7FFF, 1'b0, `HIDD_TOKEN_IN, 32'h0800,
         8'h10, 32'h2000_7F80);
    sof(FRM, 3'h4);
    chk32(32'(n_req), 32'h1);
    rdchk(`HIDD_OFS_WORD3, 32'h7FFF_FFFF, 32'h2000_7FFF);
    // A reserved token code keeps the descriptor from ever running.
    load(4'h2, 2'h1, 11'h100, 15'h7FFF, 1'b0, 2'h2, 32'h0800, 8'h10, 32'h0);
    sof(FRM, 3'h4);
    chk32(32'(n_req), 32'h1);
    rdchk(`HIDD_OFS_WORD0, 32'h1, 32'h1);
    close_out();
  end
endmodule // hs_iso_descriptor_decoder_tb_top
`default_nettype wire
